// *** timer16_pkg.sv ***
// Package with register map, field positions, reset values and types of the 16-bit capture timer.
package timer16_pkg;

  // Register word offsets (byte addresses on the APB bus).
  localparam logic [7:0] OFS_CTRL_A     = 8'h00;
  localparam logic [7:0] OFS_CTRL_B     = 8'h04;
  localparam logic [7:0] OFS_COUNT_LO   = 8'h08;
  localparam logic [7:0] OFS_COUNT_HI   = 8'h0c;
  localparam logic [7:0] OFS_CAPTURE_LO = 8'h10;
  localparam logic [7:0] OFS_CAPTURE_HI = 8'h14;
  localparam logic [7:0] OFS_COMPARE_LO = 8'h18;
  localparam logic [7:0] OFS_COMPARE_HI = 8'h1c;
  localparam logic [7:0] OFS_IRQ_FLAGS  = 8'h20;
  localparam logic [7:0] OFS_IRQ_MASK   = 8'h24;
  localparam logic [7:0] OFS_CMP_CTRL   = 8'h28;

  // Field positions.
  localparam int CTRL_A_WGM_LO    = 0;  // waveform_mode_sel[1:0] in timer_ctrl_a[1:0]
  localparam int CTRL_B_TICK_SEL  = 0;  // tick_source_sel in timer_ctrl_b[2:0]
  localparam int CTRL_B_WGM_HI    = 3;  // waveform_mode_sel[3:2] in timer_ctrl_b[4:3]
  localparam int CTRL_B_EDGE_SEL  = 6;  // capture_edge_sel
  localparam int CTRL_B_FILTER_EN = 7;  // noise_filter_enable
  localparam int FLAG_OVERFLOW    = 0;
  localparam int FLAG_CAPTURE     = 5;
  localparam int CMP_CAPTURE_SEL  = 2;  // comparator_capture_sel in comparator_ctrl_status

  // Reset values and constants.
  localparam logic [7:0]  RESET_BYTE   = 8'h00;
  localparam logic [15:0] COUNT_BOTTOM = 16'h0000;
  localparam logic [15:0] COUNT_MAX    = 16'hffff;
  localparam logic [15:0] TOP_8BIT     = 16'h00ff;
  localparam logic [15:0] TOP_9BIT     = 16'h01ff;
  localparam logic [15:0] TOP_10BIT    = 16'h03ff;
  localparam int          FILTER_SAMPLES = 4;

  // Tick source selection codes.
  localparam logic [2:0] TICK_STOP     = 3'h0;
  localparam logic [2:0] TICK_CORE     = 3'h1;
  localparam logic [2:0] TICK_EXT_FALL = 3'h6;
  localparam logic [2:0] TICK_EXT_RISE = 3'h7;

  // Counter direction machine.
  typedef enum logic [0:0] {DIR_UP = 1'b0, DIR_DOWN = 1'b1} dir_t;

  // Synchronised inputs.
  typedef struct packed {
    logic [1:0] cap_pin;
    logic [1:0] cmp_out;
    logic [1:0] ext_pin;
  } sync_t;

  // Whole module state.
  typedef struct packed {
    sync_t       sync;
    logic        ext_prev;
    logic [3:0]  filt_hist;
    logic        filt_out;
    logic        trig_prev;
    logic        src_sel_prev;
    logic [7:0]  ctrl_a;
    logic [7:0]  ctrl_b;
    logic [7:0]  cmp_ctrl;
    logic [7:0]  irq_mask;
    logic [7:0]  temp_hi;
    logic [15:0] count_value;
    logic [15:0] capture_value;
    logic [15:0] compare_value;
    dir_t        dir;
    logic        overflow_flag;
    logic        capture_flag;
    logic        pready;
    logic [31:0] prdata;
    logic        pslverr;
    logic        irq_overflow;
    logic        irq_capture;
    logic        at_top;
    logic        at_bottom;
  } state_t;

endpackage

// *** timer16_capture.sv ***
// Top module of the 16-bit up/down timer with input capture, reached over APB.
//
// Implementation choices: the APB interface to the registers and the address map.
`timescale 1ns/1ps
module timer16_capture (
  input  wire logic        CORE_CLK,
  input  wire logic        RSTN,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic             PREADY,
  output logic [31:0]      PRDATA,
  output logic             PSLVERR,
  input  wire logic        PRESCALE_TICK,
  input  wire logic        EXT_TICK_PIN,
  input  wire logic        CAPTURE_PIN,
  input  wire logic        COMPARATOR_OUTPUT,
  input  wire logic        IRQ_OVERFLOW_ACK,
  input  wire logic        IRQ_CAPTURE_ACK,
  output logic             IRQ_OVERFLOW,
  output logic             IRQ_CAPTURE,
  output logic             COUNT_AT_TOP,
  output logic             COUNT_AT_BOTTOM
);

  timer16_pkg::state_t st;
  timer16_pkg::state_t next_st;

  // Returns true for waveform modes whose top comes from the capture register.
  function automatic logic capture_is_top(input logic [3:0] mode);
    capture_is_top = (mode == 4'h8) || (mode == 4'ha) || (mode == 4'hc) || (mode == 4'he);
  endfunction

  // Returns the top value of the sequence for a given mode.
  function automatic logic [15:0] top_of(input logic [3:0] mode, input logic [15:0] cap,
                                         input logic [15:0] cmp);
    case (mode)
      4'h1, 4'h5:             top_of = timer16_pkg::TOP_8BIT;
      4'h2, 4'h6:             top_of = timer16_pkg::TOP_9BIT;
      4'h3, 4'h7:             top_of = timer16_pkg::TOP_10BIT;
      4'h4, 4'h9, 4'hb, 4'hf: top_of = cmp;
      4'h8, 4'ha, 4'hc, 4'he: top_of = cap;
      default:                top_of = timer16_pkg::COUNT_MAX;
    endcase
  endfunction

  // Returns true for the dual-slope (up/down) modes.
  function automatic logic dual_slope(input logic [3:0] mode);
    dual_slope = (mode == 4'h1) || (mode == 4'h2) || (mode == 4'h3) || (mode[3:2] == 2'b10);
  endfunction

  // Returns true for the word addresses that hold a register.
  // Every other address answers with a slave error and has no effect.
  function automatic logic is_mapped(input logic [7:0] addr);
    case (addr)
      timer16_pkg::OFS_CTRL_A,
      timer16_pkg::OFS_CTRL_B,
      timer16_pkg::OFS_COUNT_LO,
      timer16_pkg::OFS_COUNT_HI,
      timer16_pkg::OFS_CAPTURE_LO,
      timer16_pkg::OFS_CAPTURE_HI,
      timer16_pkg::OFS_COMPARE_LO,
      timer16_pkg::OFS_COMPARE_HI,
      timer16_pkg::OFS_IRQ_FLAGS,
      timer16_pkg::OFS_IRQ_MASK,
      timer16_pkg::OFS_CMP_CTRL: is_mapped = 1'b1;
      default:                   is_mapped = 1'b0;
    endcase
  endfunction

  // Whole next-state computation: sync, tick, counter, capture, flags and bus.
  always_comb begin
    logic [3:0]  mode;
    logic [15:0] top;
    logic        tick;
    logic        setup;
    logic        wr;
    logic        rd;
    logic        trig;
    logic        edge_hit;
    logic        gate;
    logic [7:0]  wbyte;
    logic        ovf_set;
    logic        cnt_write;
    mode      = 4'h0;
    top       = 16'h0000;
    tick      = 1'b0;
    setup     = 1'b0;
    wr        = 1'b0;
    rd        = 1'b0;
    trig      = 1'b0;
    edge_hit  = 1'b0;
    gate      = 1'b0;
    wbyte     = 8'h00;
    ovf_set   = 1'b0;
    cnt_write = 1'b0;
    next_st   = st;

    // Two-flop synchronisers on every foreign input.
    next_st.sync.cap_pin = {st.sync.cap_pin[0], CAPTURE_PIN};
    next_st.sync.cmp_out = {st.sync.cmp_out[0], COMPARATOR_OUTPUT};
    next_st.sync.ext_pin = {st.sync.ext_pin[0], EXT_TICK_PIN};
    next_st.ext_prev     = st.sync.ext_pin[1];

    mode = {st.ctrl_b[timer16_pkg::CTRL_B_WGM_HI +: 2], st.ctrl_a[timer16_pkg::CTRL_A_WGM_LO +: 2]};
    top  = top_of(mode, st.capture_value, st.compare_value);

    // Timer tick selection.
    case (st.ctrl_b[timer16_pkg::CTRL_B_TICK_SEL +: 3])
      timer16_pkg::TICK_STOP:     tick = 1'b0;
      timer16_pkg::TICK_CORE:     tick = 1'b1;
      timer16_pkg::TICK_EXT_FALL: tick = st.ext_prev & ~st.sync.ext_pin[1];
      timer16_pkg::TICK_EXT_RISE: tick = ~st.ext_prev & st.sync.ext_pin[1];
      default:                    tick = PRESCALE_TICK;
    endcase

    // Bus decode: ready, read data and error are all registered from the setup cycle.
    // They therefore stand together in the access cycle; writes land at the access edge.
    setup = PSEL & ~PENABLE;
    wr    = PSEL & PENABLE & PWRITE;
    rd    = setup & ~PWRITE;
    wbyte = PWDATA[7:0];
    next_st.pready  = setup;
    next_st.pslverr = setup & ~is_mapped(PADDR);
    next_st.prdata  = 32'h0000_0000;

    // Counter sequence.
    if (tick) begin
      if (dual_slope(mode)) begin
        if (st.dir == timer16_pkg::DIR_UP) begin
          if (st.count_value >= top) begin
            next_st.dir         = timer16_pkg::DIR_DOWN;
            next_st.count_value = st.count_value - 16'h0001;
          end else begin
            next_st.count_value = st.count_value + 16'h0001;
          end
        end else if (st.count_value == timer16_pkg::COUNT_BOTTOM) begin
          next_st.dir         = timer16_pkg::DIR_UP;
          next_st.count_value = st.count_value + 16'h0001;
          ovf_set             = 1'b1;
        end else begin
          next_st.count_value = st.count_value - 16'h0001;
        end
      end else if (st.count_value == top) begin
        next_st.count_value = timer16_pkg::COUNT_BOTTOM;
        ovf_set             = (mode == 4'h0) || (mode[1:0] != 2'b00) || mode[3];
      end else begin
        next_st.count_value = st.count_value + 16'h0001;
      end
    end

    // Register writes; counter write wins over the count above.
    if (wr) begin
      case (PADDR)
        timer16_pkg::OFS_CTRL_A:   next_st.ctrl_a   = wbyte;
        timer16_pkg::OFS_CTRL_B:   next_st.ctrl_b   = wbyte;
        timer16_pkg::OFS_CMP_CTRL: next_st.cmp_ctrl = wbyte;
        timer16_pkg::OFS_IRQ_MASK: next_st.irq_mask = wbyte;
        timer16_pkg::OFS_COUNT_HI, timer16_pkg::OFS_CAPTURE_HI, timer16_pkg::OFS_COMPARE_HI:
          next_st.temp_hi = wbyte;
        timer16_pkg::OFS_COUNT_LO: begin
          next_st.count_value = {st.temp_hi, wbyte};
          cnt_write           = 1'b1;
        end
        timer16_pkg::OFS_CAPTURE_LO:
          if (capture_is_top(mode)) next_st.capture_value = {st.temp_hi, wbyte};
        timer16_pkg::OFS_COMPARE_LO: next_st.compare_value = {st.temp_hi, wbyte};
        timer16_pkg::OFS_IRQ_FLAGS: ;
        default: ;
      endcase
    end

    // Register reads, prepared in the setup cycle so the data stands with the ready pulse.
    if (rd) begin
      case (PADDR)
        timer16_pkg::OFS_CTRL_A:   next_st.prdata[7:0] = st.ctrl_a;
        timer16_pkg::OFS_CTRL_B:   next_st.prdata[7:0] = st.ctrl_b;
        timer16_pkg::OFS_CMP_CTRL: next_st.prdata[7:0] = st.cmp_ctrl;
        timer16_pkg::OFS_IRQ_MASK: next_st.prdata[7:0] = st.irq_mask;
        timer16_pkg::OFS_IRQ_FLAGS: begin
          next_st.prdata[timer16_pkg::FLAG_OVERFLOW] = st.overflow_flag;
          next_st.prdata[timer16_pkg::FLAG_CAPTURE]  = st.capture_flag;
        end
        timer16_pkg::OFS_COUNT_LO: begin
          next_st.prdata[7:0] = st.count_value[7:0];
          next_st.temp_hi     = st.count_value[15:8];
        end
        timer16_pkg::OFS_CAPTURE_LO: begin
          next_st.prdata[7:0] = st.capture_value[7:0];
          next_st.temp_hi     = st.capture_value[15:8];
        end
        timer16_pkg::OFS_COUNT_HI, timer16_pkg::OFS_CAPTURE_HI:
          next_st.prdata[7:0] = st.temp_hi;
        timer16_pkg::OFS_COMPARE_LO: next_st.prdata[7:0] = st.compare_value[7:0];
        timer16_pkg::OFS_COMPARE_HI: next_st.prdata[7:0] = st.compare_value[15:8];
        default: ;
      endcase
    end

    // Trigger source, filter and edge detector, gated off when capture is top.
    gate = ~capture_is_top(mode);
    trig = st.cmp_ctrl[timer16_pkg::CMP_CAPTURE_SEL] ? st.sync.cmp_out[1] : st.sync.cap_pin[1];
    next_st.src_sel_prev = st.cmp_ctrl[timer16_pkg::CMP_CAPTURE_SEL];
    if (gate) begin
      next_st.filt_hist = {st.filt_hist[2:0], trig};
      if (st.ctrl_b[timer16_pkg::CTRL_B_FILTER_EN]) begin
        if (&st.filt_hist || ~|st.filt_hist) begin
          next_st.filt_out = st.filt_hist[timer16_pkg::FILTER_SAMPLES-1];
        end
      end else begin
        next_st.filt_out = trig;
      end
      next_st.trig_prev = st.filt_out;
      edge_hit = st.ctrl_b[timer16_pkg::CTRL_B_EDGE_SEL] ? (~st.trig_prev & st.filt_out)
                                                         : (st.trig_prev & ~st.filt_out);
    end

    // Capture copies the counter and sets the flag in the same cycle.
    if (edge_hit) begin
      next_st.capture_value = st.count_value;
    end

    // Flag clears: acknowledge or write-one; a set in the same cycle wins.
    if (IRQ_CAPTURE_ACK || (wr && PADDR == timer16_pkg::OFS_IRQ_FLAGS && PWDATA[timer16_pkg::FLAG_CAPTURE])) begin
      next_st.capture_flag = 1'b0;
    end
    if (IRQ_OVERFLOW_ACK || (wr && PADDR == timer16_pkg::OFS_IRQ_FLAGS && PWDATA[timer16_pkg::FLAG_OVERFLOW])) begin
      next_st.overflow_flag = 1'b0;
    end
    if (edge_hit) begin
      next_st.capture_flag = 1'b1;
    end
    if (ovf_set && !cnt_write) begin
      next_st.overflow_flag = 1'b1;
    end

    // Interrupt requests and position indications.
    next_st.irq_capture  = next_st.capture_flag & next_st.irq_mask[timer16_pkg::FLAG_CAPTURE];
    next_st.irq_overflow = next_st.overflow_flag & next_st.irq_mask[timer16_pkg::FLAG_OVERFLOW];
    next_st.at_bottom    = (next_st.count_value == timer16_pkg::COUNT_BOTTOM);
    next_st.at_top       = (next_st.count_value == top);
  end

  // State register.
  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      st           <= '0;
      st.at_bottom <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // Outputs straight from flip-flops.
  assign PREADY          = st.pready;
  assign PRDATA          = st.prdata;
  assign PSLVERR         = st.pslverr;
  assign IRQ_OVERFLOW    = st.irq_overflow;
  assign IRQ_CAPTURE     = st.irq_capture;
  assign COUNT_AT_TOP    = st.at_top;
  assign COUNT_AT_BOTTOM = st.at_bottom;

endmodule

// *** timer16_chk.sv ***
// Checker of the bus handshake and interrupt clearing at the timer ports.
`timescale 1ns/1ps
module timer16_chk (
  input wire logic        CORE_CLK,
  input wire logic        RSTN,
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic [7:0]  PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic        PREADY,
  input wire logic [31:0] PRDATA,
  input wire logic        PSLVERR,
  input wire logic        IRQ_OVERFLOW_ACK,
  input wire logic        IRQ_CAPTURE_ACK,
  input wire logic        IRQ_OVERFLOW,
  input wire logic        IRQ_CAPTURE
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RSTN);
  // Setup phase, and an access phase that writes a given value to the capture bit at a given address.
  sequence s_setup;
    PSEL && !PENABLE;
  endsequence
  sequence s_cap_write(a, v);
    PSEL && PENABLE && PWRITE && PADDR == a && PWDATA[5] == v;
  endsequence
  property p_ready_after_setup; s_setup |=> PREADY; endproperty
  property p_ready_pulse; PREADY |=> !PREADY; endproperty
  property p_ready_cause; PREADY |-> $past(PSEL && !PENABLE); endproperty
  property p_rdata_clean; PREADY |-> PRDATA[31:8] == 24'h000000; endproperty
  property p_err_unmapped; PREADY && PADDR > 8'h28 |-> PSLVERR; endproperty
  property p_err_with_ready; PSLVERR |-> PREADY && PADDR > 8'h28; endproperty
  property p_cap_ack; IRQ_CAPTURE_ACK |-> ##2 !IRQ_CAPTURE; endproperty
  property p_cap_w1c; s_cap_write(8'h20, 1'b1) |-> ##2 !IRQ_CAPTURE; endproperty
  property p_cap_mask; s_cap_write(8'h24, 1'b0) |-> ##2 !IRQ_CAPTURE; endproperty
  property p_ovf_ack; IRQ_OVERFLOW_ACK |-> ##2 !IRQ_OVERFLOW; endproperty
  a_ready_after_setup: assert property (p_ready_after_setup) else $error("no ready after setup");
  a_ready_pulse: assert property (p_ready_pulse) else $error("ready held too long");
  a_ready_cause: assert property (p_ready_cause) else $error("ready without setup");
  a_rdata_clean: assert property (p_rdata_clean) else $error("read data upper bits set");
  a_err_unmapped: assert property (p_err_unmapped) else $error("unmapped access not flagged");
  a_err_with_ready: assert property (p_err_with_ready) else $error("stray slave error");
  a_cap_ack: assert property (p_cap_ack) else $error("capture ack left request");
  a_cap_w1c: assert property (p_cap_w1c) else $error("capture write one left request");
  a_cap_mask: assert property (p_cap_mask) else $error("masked capture still requests");
  a_ovf_ack: assert property (p_ovf_ack) else $error("overflow ack left request");
endmodule

// *** timer16_far.sv ***
// Model of the external capture signal sources: capture pin and comparator output.
`timescale 1ns/1ps
module timer16_far (
  input  wire logic CORE_CLK,
  output logic      cap_pin,
  output logic      cmp_out
);
  initial begin
    cap_pin = 1'b0;
    cmp_out = 1'b0;
  end
  // Sets a level just after a clock edge; the level stays until changed again.
  task automatic drive(input bit cmp, input bit lvl);
    @(posedge CORE_CLK);
    if (cmp) cmp_out <= lvl;
    else cap_pin <= lvl;
  endtask
  // Flips the pin for n cycles only, shorter than the filter span when n is below four.
  task automatic glitch(input int n);
    drive(1'b0, ~cap_pin);
    repeat (n - 1) @(posedge CORE_CLK);
    drive(1'b0, ~cap_pin);
  endtask
endmodule

// *** tb_top.sv ***
// Self-checking bench for the capture timer, with an APB master and fixed expected values.
`timescale 1ns/1ps
module tb_top;
  logic        core_clk, rstn, psel, penable, pwrite, pready, pslverr, err;
  logic        ovf_ack, cap_ack, irq_ovf, irq_cap, at_top, at_bot, cap_pin, cmp_out, ext_pin, pre_tick;
  logic [7:0]  paddr;
  logic [15:0] v;
  logic [31:0] pwdata, prdata, r;
  int          mismatches, compares, cycles, seed, d0, d1, m_count;
  timer16_capture timer16_capture_i (.CORE_CLK(core_clk), .RSTN(rstn), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PREADY(pready), .PRDATA(prdata), .PSLVERR(pslverr),
    .PRESCALE_TICK(pre_tick), .EXT_TICK_PIN(ext_pin), .CAPTURE_PIN(cap_pin), .COMPARATOR_OUTPUT(cmp_out),
    .IRQ_OVERFLOW_ACK(ovf_ack), .IRQ_CAPTURE_ACK(cap_ack), .IRQ_OVERFLOW(irq_ovf), .IRQ_CAPTURE(irq_cap),
    .COUNT_AT_TOP(at_top), .COUNT_AT_BOTTOM(at_bot));
  timer16_far timer16_far_i (.CORE_CLK(core_clk), .cap_pin(cap_pin), .cmp_out(cmp_out));
  // Clock and hang guard.
  initial core_clk = 1'b0;
  always #5 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cycles = cycles + 1;
    if (cycles == 20000) begin
      mismatches++;
      close_out();
    end
  end
  // Comparison, bus transfer and paired byte access helpers.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= {24'h000000, d};
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    r = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (n == 16) chk(32'h0, 32'h1);
  endtask
  task automatic wr16(input logic [7:0] a, input logic [15:0] w);
    apb(1'b1, a + 8'h04, w[15:8]);
    apb(1'b1, a, w[7:0]);
  endtask
  task automatic rd16(input logic [7:0] a);
    apb(1'b0, a, 8'h00);
    v[7:0] = r[7:0];
    apb(1'b0, a + 8'h04, 8'h00);
    v[15:8] = r[7:0];
  endtask
  task automatic wait_irq(input bit ovf, output int d);
    d = 0;
    while ((ovf ? irq_ovf : irq_cap) !== 1'b1 && d < 40) begin
      @(posedge core_clk);
      d++;
    end
  endtask
  task automatic close_out();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // Main sequence: latch access, capture paths, filter, counting and error response.
  initial begin
    {rstn, psel, penable, pwrite, ovf_ack, cap_ack, ext_pin, pre_tick, paddr, pwdata} = '0;
    {mismatches, compares, cycles} = '0;
    seed = 5190;
    repeat (4) @(posedge core_clk);
    rstn <= 1'b1;
    @(posedge core_clk);
    chk(at_bot, 1'b1);
    m_count = {$random(seed)} % 65535 + 1;
    wr16(timer16_pkg::OFS_COUNT_LO, m_count[15:0]);
    repeat (20) @(posedge core_clk);
    rd16(timer16_pkg::OFS_COUNT_LO);
    chk(v, m_count);
    chk(at_bot, 1'b0);
    wr16(timer16_pkg::OFS_COMPARE_LO, 16'h5aa5);
    apb(1'b1, timer16_pkg::OFS_COUNT_HI, 8'h3c);
    apb(1'b0, timer16_pkg::OFS_COMPARE_HI, 8'h00);
    chk(r, 32'h5a);
    // The latch still holds the high byte loaded above; a second register reuses it.
    apb(1'b1, timer16_pkg::OFS_COMPARE_LO, 8'h11);
    rd16(timer16_pkg::OFS_COMPARE_LO);
    chk(v, 16'h3c11);
    wr16(timer16_pkg::OFS_CAPTURE_LO, 16'h1234);
    rd16(timer16_pkg::OFS_CAPTURE_LO);
    chk(v, 16'h0000);
    apb(1'b1, timer16_pkg::OFS_IRQ_MASK, 8'h21);
    apb(1'b1, timer16_pkg::OFS_CTRL_B, 8'h18);
    wr16(timer16_pkg::OFS_CAPTURE_LO, 16'h1234);
    rd16(timer16_pkg::OFS_CAPTURE_LO);
    chk(v, 16'h1234);
    wr16(timer16_pkg::OFS_COUNT_LO, 16'h1234);
    repeat (3) @(posedge core_clk);
    chk(at_top, 1'b1);
    timer16_far_i.drive(1'b0, 1'b1);
    wait_irq(1'b0, d1);
    chk(d1, 40);
    timer16_far_i.drive(1'b0, 1'b0);
    repeat (8) @(posedge core_clk);
    apb(1'b1, timer16_pkg::OFS_CTRL_B, 8'h40);
    m_count = {$random(seed)} % 65536;
    wr16(timer16_pkg::OFS_COUNT_LO, m_count[15:0]);
    apb(1'b1, timer16_pkg::OFS_IRQ_FLAGS, 8'h20);
    timer16_far_i.drive(1'b0, 1'b1);
    wait_irq(1'b0, d0);
    chk(d0 > 2 && d0 < 40, 1'b1);
    rd16(timer16_pkg::OFS_CAPTURE_LO);
    chk(v, m_count);
    apb(1'b0, timer16_pkg::OFS_IRQ_FLAGS, 8'h00);
    chk(r[5], 1'b1);
    cap_ack <= 1'b1;
    @(posedge core_clk);
    cap_ack <= 1'b0;
    repeat (3) @(posedge core_clk);
    chk(irq_cap, 1'b0);
    m_count = {$random(seed)} % 65536;
    wr16(timer16_pkg::OFS_COUNT_LO, m_count[15:0]);
    apb(1'b1, timer16_pkg::OFS_CTRL_B, 8'hc0);
    repeat (8) @(posedge core_clk);
    apb(1'b1, timer16_pkg::OFS_IRQ_FLAGS, 8'h20);
    timer16_far_i.drive(1'b0, 1'b0);
    wait_irq(1'b0, d1);
    chk(d1, 40);
    timer16_far_i.drive(1'b0, 1'b1);
    wait_irq(1'b0, d1);
    chk(d1, d0 + 4);
    rd16(timer16_pkg::OFS_CAPTURE_LO);
    chk(v, m_count);
    apb(1'b1, timer16_pkg::OFS_IRQ_FLAGS, 8'h20);
    timer16_far_i.drive(1'b0, 1'b0);
    repeat (12) @(posedge core_clk);
    chk(irq_cap, 1'b0);
    timer16_far_i.glitch(3);
    wait_irq(1'b0, d1);
    chk(d1, 40);
    apb(1'b1, timer16_pkg::OFS_CMP_CTRL, 8'h04);
    repeat (8) @(posedge core_clk);
    apb(1'b1, timer16_pkg::OFS_IRQ_FLAGS, 8'h20);
    timer16_far_i.drive(1'b1, 1'b1);
    wait_irq(1'b0, d1);
    chk(d1, d0 + 4);
    wr16(timer16_pkg::OFS_COUNT_LO, 16'hfff0);
    apb(1'b1, timer16_pkg::OFS_CTRL_B, 8'h01);
    wait_irq(1'b1, d1);
    apb(1'b1, timer16_pkg::OFS_CTRL_B, 8'h00);
    rd16(timer16_pkg::OFS_COUNT_LO);
    chk(d1 < 40 && v < 16'h0020, 1'b1);
    m_count = v;
    repeat (10) @(posedge core_clk);
    rd16(timer16_pkg::OFS_COUNT_LO);
    chk(v, m_count);
    // Three rising edges on the external tick pin, then five prescaler ticks.
    apb(1'b1, timer16_pkg::OFS_CTRL_B, 8'h07);
    repeat (3) begin
      ext_pin <= 1'b1;
      repeat (4) @(posedge core_clk);
      ext_pin <= 1'b0;
      repeat (4) @(posedge core_clk);
    end
    apb(1'b1, timer16_pkg::OFS_CTRL_B, 8'h02);
    repeat (5) begin
      pre_tick <= 1'b1;
      @(posedge core_clk);
      pre_tick <= 1'b0;
      @(posedge core_clk);
    end
    apb(1'b1, timer16_pkg::OFS_CTRL_B, 8'h00);
    rd16(timer16_pkg::OFS_COUNT_LO);
    chk(v, m_count + 8);
    ovf_ack <= 1'b1;
    @(posedge core_clk);
    ovf_ack <= 1'b0;
    repeat (3) @(posedge core_clk);
    chk(irq_ovf, 1'b0);
    apb(1'b1, timer16_pkg::OFS_IRQ_MASK, 8'h00);
    repeat (2) @(posedge core_clk);
    chk(irq_cap, 1'b0);
    apb(1'b0, 8'h40, 8'h00);
    chk(err, 1'b1);
    close_out();
  end
endmodule
bind timer16_capture timer16_chk timer16_chk_i (.CORE_CLK(CORE_CLK), .RSTN(RSTN), .PSEL(PSEL), .PENABLE(PENABLE),
  .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PREADY(PREADY), .PRDATA(PRDATA), .PSLVERR(PSLVERR),
  .IRQ_OVERFLOW_ACK(IRQ_OVERFLOW_ACK), .IRQ_CAPTURE_ACK(IRQ_CAPTURE_ACK), .IRQ_OVERFLOW(IRQ_OVERFLOW),
  .IRQ_CAPTURE(IRQ_CAPTURE));
